// file: hw/prs_pad_ctrl.sv
// pad state controller: reset and default configuration of interface pads
// assumes a single 25 MHz ref_clk and asynchronous active-high rst
// Operation
// - in reset the pixel clock and eight pixel bits float, afterwards they drive 0 while the interface is off.
// - the extra low bits float in reset, their input buffers are off by default and bit0 drives 0.
// - after reset the extra low bit buffers power up, are sampled, then power down again.
// - the video dac pads are off in reset and turn on once streaming starts.
// - test data out floats except during the shift phases of the test port.
// - test data in, mode select and test clock keep pull-ups on in reset and by default.
// - floating pads keep their output drivers disabled and input buffers off, except extra low bit1, whose buffer is on during the strap sample window.
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_pad_ctrl #(
  parameter int SAMPLE_CYCLES = `PRS_SAMPLE_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                pix_enable,
  input  wire logic [7:0]          pix_data,
  input  wire logic                pix_clk_in,
  input  wire logic                streaming,
  input  wire logic                tdo_data,
  input  wire logic                tap_shift,
  input  wire logic [1:0]          low_pad_in,
  output prs_pkg::prs_pix_pads_s   pix_pads,
  output prs_pkg::prs_low_pads_s   low_pads,
  output logic                     dac_enable,
  output logic                     tdo_out,
  output logic                     tdo_oe_n,
  output logic [2:0]               jtag_pullup_en,
  output logic [1:0]               strap_value,
  output logic                     config_done
);
  import prs_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // below 3 dwell cycles the capture would read the synchroniser before the powered pad level reached it
  if (SAMPLE_CYCLES < 3 || SAMPLE_CYCLES > 7) begin : g_bad_sample_cycles
    $error("SAMPLE_CYCLES out of range");
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  prs_state_e state_reg;
  prs_state_e state_next;
  logic [`PRS_SAMPLE_CNT_W-1:0] cnt_reg;
  logic [`PRS_SAMPLE_CNT_W-1:0] cnt_next;
  localparam logic [`PRS_SAMPLE_CNT_W-1:0] CNT_LAST = `PRS_SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      PRS_ST_RESET: begin
        state_next = PRS_ST_POWERUP;
      end
      PRS_ST_POWERUP: begin
        // synchroniser needs its two stages to settle before capture
        if (cnt_reg == CNT_LAST) begin
          state_next = PRS_ST_SAMPLE;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PRS_ST_SAMPLE: begin
        state_next = PRS_ST_DEFAULT;
      end
      PRS_ST_DEFAULT: begin
        state_next = PRS_ST_DEFAULT;
      end
      default: begin
        state_next = PRS_ST_DEFAULT;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PRS_ST_RESET;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  wire in_reset   = (state_reg == PRS_ST_RESET);
  wire buf_window = (state_reg == PRS_ST_POWERUP) || (state_reg == PRS_ST_SAMPLE);
  wire capture    = (state_reg == PRS_ST_SAMPLE);

  prs_strap_sampler u_sampler (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pad_in      (low_pad_in),
    .capture     (capture),
    .strap_value (strap_value)
  );

  // ----------------------------------------
  // pad configuration
  // ----------------------------------------
  // outputs registered (pull-up enables tied high) so pad controls never glitch on logic changes
  prs_pix_pads_s pix_reg;
  prs_pix_pads_s pix_next;
  prs_low_pads_s low_reg;
  prs_low_pads_s low_next;
  logic          dac_reg;
  logic          tdo_reg;
  logic          tdo_oe_n_reg;
  logic          done_reg;

  wire pix_live = pix_enable && !in_reset;

  // the async reset holds the floating configuration, so the first edge after release loads the default
  always_comb begin
    pix_next.oe_n     = '0;
    pix_next.clk_oe_n = 1'b0;
    pix_next.data     = pix_live ? pix_data : {`PRS_PIX_WIDTH{`PRS_DRIVE_LOW}};
    pix_next.clk_out  = pix_live ? pix_clk_in : `PRS_DRIVE_LOW;
    // bit1 floats always, bit0 drives low after reset
    low_next.oe_n     = 2'h2;
    low_next.out      = {2{`PRS_DRIVE_LOW}};
    low_next.ibuf_en  = buf_window ? 2'h3 : 2'h0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pix_reg      <= '{data: '0, oe_n: '1, clk_out: 1'b0, clk_oe_n: 1'b1};
      low_reg      <= '{out: 2'h0, oe_n: 2'h3, ibuf_en: 2'h0};
      dac_reg      <= 1'b0;
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
      done_reg     <= 1'b0;
    end else begin
      pix_reg      <= pix_next;
      low_reg      <= low_next;
      dac_reg      <= streaming && !in_reset;
      tdo_reg      <= tdo_data;
      tdo_oe_n_reg <= !tap_shift;
      done_reg     <= (state_reg == PRS_ST_DEFAULT);
    end
  end

  assign pix_pads       = pix_reg;
  assign low_pads       = low_reg;
  assign dac_enable     = dac_reg;
  assign tdo_out        = tdo_reg;
  assign tdo_oe_n       = tdo_oe_n_reg;
  assign jtag_pullup_en = 3'h7;
  assign config_done    = done_reg;
  // the board must hold test reset, frame sync and analogue test pins valid; no logic here relies on them

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // until the first edge after release the pads still show the reset configuration
  chk_pix_float_reset: assert property (@(posedge ref_clk) disable iff (rst)
    in_reset |-> (pix_pads.oe_n == '1) && pix_pads.clk_oe_n) else $error("pixel pads not floating in reset");
  chk_pix_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
    (!in_reset && !pix_enable) |=> (pix_pads.oe_n == '0) && (pix_pads.data == '0)) else $error("idle pixel pads not low");
  chk_pix_pass: assert property (@(posedge ref_clk) disable iff (rst)
    pix_live |=> (pix_pads.data == $past(pix_data)) && (pix_pads.clk_out == $past(pix_clk_in)))
    else $error("pixel data not passed");
  chk_low_bit1_float: assert property (@(posedge ref_clk) disable iff (rst)
    low_pads.oe_n[1]) else $error("extra bit1 driven");
  chk_low_bit0_drive: assert property (@(posedge ref_clk) disable iff (rst)
    !in_reset |-> !low_pads.oe_n[0] && !low_pads.out[0]) else $error("extra bit0 not driven low");
  // bit0 drives its own pin low while sampled, so its strap always reads 0; only bit1 carries a board level
  chk_strap_sequence: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(capture) |-> (low_pads.ibuf_en == 2'h3) ##1 (strap_value == $past(u_sampler.sync2_reg))
      ##1 (low_pads.ibuf_en == 2'h0)) else $error("strap sample sequence wrong");
  chk_ibuf_powerup: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == PRS_ST_POWERUP) |=> (low_pads.ibuf_en == 2'h3)) else $error("strap buffers not powered");
  chk_strap_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == PRS_ST_DEFAULT) |=> $stable(strap_value)) else $error("strap value moved after capture");
  chk_no_early_done: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg != PRS_ST_DEFAULT) |=> !config_done) else $error("config done too early");
  chk_done_after_cfg: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == PRS_ST_DEFAULT) |=> config_done) else $error("config done missing");
  chk_dac_off_reset: assert property (@(posedge ref_clk) disable iff (rst)
    in_reset |-> !dac_enable) else $error("dac enabled in reset");
  chk_dac_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (streaming && !in_reset) |=> dac_enable) else $error("dac not enabled on streaming");
  chk_dac_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !streaming |=> !dac_enable) else $error("dac enabled without streaming");
  chk_tdo_shift_only: assert property (@(posedge ref_clk) disable iff (rst)
    !tdo_oe_n |-> $past(tap_shift)) else $error("tdo driven outside shift");
  chk_tdo_float_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !tap_shift |=> tdo_oe_n) else $error("tdo not floating outside shift");
  chk_tdo_drive_shift: assert property (@(posedge ref_clk) disable iff (rst)
    tap_shift |=> !tdo_oe_n && (tdo_out == $past(tdo_data))) else $error("tdo not driven in shift");
  chk_pullups_on: assert property (@(posedge ref_clk) disable iff (rst)
    jtag_pullup_en == 3'h7) else $error("pull-up dropped");
  chk_float_no_ibuf: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == PRS_ST_DEFAULT) ##1 1'b1 |-> (low_pads.ibuf_en == 2'h0)) else $error("floating pad buffer powered");
  chk_leave_reset: assert property (@(posedge ref_clk) disable iff (rst)
    in_reset |=> !pix_pads.clk_oe_n && (pix_pads.oe_n == '0) && (low_pads.oe_n == 2'h2)
      && (state_reg == PRS_ST_POWERUP)) else $error("reset state held too long");
  chk_state_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot(state_reg)) else $error("state register not one-hot");

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // counts sampled edges with the strap buffers powered
  // four bits cover the largest allowed dwell plus the capture cycle
  logic [3:0] ibuf_on_cnt_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ibuf_on_cnt_reg <= 4'h0;
    end else begin
      ibuf_on_cnt_reg <= ibuf_on_cnt_reg + {3'h0, |low_pads.ibuf_en};
    end
  end

  chk_ibuf_dwell_len: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(low_pads.ibuf_en[0]) |-> (ibuf_on_cnt_reg == 4'(SAMPLE_CYCLES + 1)))
    else $error("strap buffers powered for wrong time");
endmodule
`default_nettype wire

// file: hw/prs_params.svh
// pad reset/default state constants
// assumes inclusion by the pad state controller and its sampler
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_PIX_WIDTH      8
`define PRS_DRIVE_LOW      1'b0
`define PRS_SAMPLE_CYCLES  4
`define PRS_SAMPLE_CNT_W   3
`endif

// file: hw/prs_pkg.sv
// types shared by the pad state controller files
// assumes prs_params.svh is on the include path
`default_nettype none
`include "prs_params.svh"
package prs_pkg;
  typedef enum logic [3:0] {
    PRS_ST_RESET   = 4'b0001,
    PRS_ST_POWERUP = 4'b0010,
    PRS_ST_SAMPLE  = 4'b0100,
    PRS_ST_DEFAULT = 4'b1000
  } prs_state_e;

  // output enables are active low: 0 means the pad drives
  typedef struct packed {
    logic [`PRS_PIX_WIDTH-1:0] data;
    logic [`PRS_PIX_WIDTH-1:0] oe_n;
    logic                      clk_out;
    logic                      clk_oe_n;
  } prs_pix_pads_s;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
    logic [1:0] ibuf_en;
  } prs_low_pads_s;
endpackage
`default_nettype wire

// file: hw/prs_strap_sampler.sv
// two-flop synchroniser and capture for the extra low bit straps
// assumes pad inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_strap_sampler (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] pad_in,
  input  wire logic       capture,
  output logic      [1:0] strap_value
);
  import prs_pkg::*;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] strap_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      strap_reg <= 2'h0;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      if (capture) begin
        strap_reg <= sync2_reg;
      end
    end
  end
  assign strap_value = strap_reg;
endmodule
`default_nettype wire

// file: verif/prs_board_model.sv
// board side of the extra low bit pads: strap resistors and the pad wire
// assumes the pad controller's low pad struct on its inputs
`timescale 1ns/1ps
`default_nettype none
module prs_board_model #(
  parameter logic [1:0] STRAP = 2'b10
) (
  input  wire prs_pkg::prs_low_pads_s low_pads,
  output logic [1:0]                  low_pad_in
);
  import prs_pkg::*;
  // --------------------------------------------------------------
  // pad wire
  // --------------------------------------------------------------
  // a powered-down buffer shows no valid level, so feed the inverse of the strap
  logic [1:0] wire_lvl;
  assign wire_lvl[0]   = !low_pads.oe_n[0] ? low_pads.out[0] : STRAP[0];
  assign wire_lvl[1]   = !low_pads.oe_n[1] ? low_pads.out[1] : STRAP[1];
  assign low_pad_in[0] = low_pads.ibuf_en[0] ? wire_lvl[0] : ~STRAP[0];
  assign low_pad_in[1] = low_pads.ibuf_en[1] ? wire_lvl[1] : ~STRAP[1];
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the pad state controller
// assumes the board model supplies the strap levels
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prs_pkg::*;
  localparam logic [1:0] STRAP = 2'b10;
  logic          ref_clk    = 1'b0;
  logic          rst        = 1'b1;
  logic          pix_enable = 1'b0;
  logic [7:0]    pix_data   = 8'h00;
  logic          pix_clk_in = 1'b0;
  logic          streaming  = 1'b0;
  logic          tdo_data   = 1'b0;
  logic          tap_shift  = 1'b0;
  logic [1:0]    low_pad_in;
  prs_pix_pads_s pix_pads;
  prs_low_pads_s low_pads;
  logic          dac_enable;
  logic          tdo_out;
  logic          tdo_oe_n;
  logic [2:0]    jtag_pullup_en;
  logic [1:0]    strap_value;
  logic          config_done;
  int            fail_count = 0;
  int            tests_run  = 0;
  prs_pad_ctrl #(.SAMPLE_CYCLES(4)) i_prs_pad_ctrl (.ref_clk(ref_clk), .rst(rst), .pix_enable(pix_enable),
    .pix_data(pix_data), .pix_clk_in(pix_clk_in), .streaming(streaming), .tdo_data(tdo_data),
    .tap_shift(tap_shift), .low_pad_in(low_pad_in), .pix_pads(pix_pads), .low_pads(low_pads),
    .dac_enable(dac_enable), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .jtag_pullup_en(jtag_pullup_en),
    .strap_value(strap_value), .config_done(config_done));
  prs_board_model #(.STRAP(STRAP)) i_prs_board_model (.low_pads(low_pads), .low_pad_in(low_pad_in));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // outputs are settled 1 ns after the edge
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic check_reset_pads();
    chk({pix_pads.oe_n, pix_pads.clk_oe_n}, 32'h0000_01ff);
    chk({low_pads.oe_n, low_pads.ibuf_en}, 32'h0000_000c);
    chk({dac_enable, tdo_oe_n}, 32'h0000_0001);
    chk(jtag_pullup_en, 32'h0000_0007);
    chk({strap_value, config_done}, 32'h0000_0000);
    $display("test reset_pads done");
  endtask
  task automatic check_release();
    int i;
    @(posedge ref_clk);
    rst <= 1'b0;
    tick();
    chk({pix_pads.oe_n, low_pads.oe_n}, 32'h0000_0002);
    tick();
    chk({pix_pads.oe_n, pix_pads.data, pix_pads.clk_oe_n, pix_pads.clk_out}, 32'h0000_0000);
    chk({low_pads.oe_n, low_pads.out, low_pads.ibuf_en}, 32'h0000_0023);
    for (i = 0; i < 20 && config_done !== 1'b1; i++) tick();
    if (config_done !== 1'b1) begin
      chk(config_done, 32'h0000_0001);
      finish_test();
    end
    // bit0 is driven low by the pad itself while sampled
    chk({low_pads.ibuf_en, strap_value}, {28'h0, 2'b00, STRAP[1], 1'b0});
    $display("test release done");
  endtask
  task automatic check_pixels();
    @(posedge ref_clk);
    pix_enable <= 1'b1;
    pix_data   <= 8'ha5;
    pix_clk_in <= 1'b1;
    tick();
    chk({pix_pads.data, pix_pads.clk_out}, 32'h0000_014b);
    @(posedge ref_clk);
    pix_enable <= 1'b0;
    tick();
    chk({pix_pads.oe_n, pix_pads.data, pix_pads.clk_out}, 32'h0000_0000);
    $display("test pixels done");
  endtask
  task automatic check_dac_tdo();
    @(posedge ref_clk);
    streaming <= 1'b1;
    tap_shift <= 1'b1;
    tdo_data  <= 1'b1;
    tick();
    chk({dac_enable, tdo_oe_n, tdo_out}, 32'h0000_0005);
    @(posedge ref_clk);
    tap_shift <= 1'b0;
    tick();
    chk(tdo_oe_n, 32'h0000_0001);
    $display("test dac_tdo done");
  endtask
  initial begin
    repeat (6) tick();
    check_reset_pads();
    check_release();
    check_pixels();
    check_dac_tdo();
    @(posedge ref_clk);
    rst <= 1'b1;
    tick();
    check_reset_pads();
    check_release();
    finish_test();
  end
endmodule
`default_nettype wire
